// ==== include/risc_decode_pkg.sv ====
package risc_decode_pkg;

  // ==========================================================
  // Instruction fields and groups
  localparam int INSTR_W = 14;
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_XFER = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  // Fixed control words
  localparam logic [13:0] WORD_RETURN_SUB = 14'h0008;
  localparam logic [13:0] WORD_RETURN_IRQ = 14'h0009;
  localparam logic [13:0] WORD_CLEAR_WDOG = 14'h0064;
  localparam logic [13:0] WORD_STANDBY = 14'h0063;
  localparam logic [6:0] CLEAR_ACC_LOW = 7'h03;

  // ==========================================================
  // Flag masks: bit0 C, bit1 digit carry, bit2 Z, bit3 timeout/powerdown
  localparam logic [3:0] FLAGS_NONE = 4'h0;
  localparam logic [3:0] FLAGS_C = 4'h1;
  localparam logic [3:0] FLAGS_Z = 4'h4;
  localparam logic [3:0] FLAGS_CDZ = 4'h7;
  localparam logic [3:0] FLAGS_TOPD = 4'h8;

  // ==========================================================
  // Timing: oscillator periods per instruction cycle
  localparam int OSC_PERIODS_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PERIODS_PER_CYCLE - 1);
  localparam logic [6:0] TIMER_ZERO_ADDR_DEF = 7'h01;

  // ==========================================================
  // Register map (byte addresses) and reset values
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_OPERAND = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_DECODE = 8'h0C;
  localparam logic [7:0] OFF_LITERAL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [13:0] INSTR_RESET = 14'h0000;
  localparam logic [7:0] OPERAND_RESET = 8'h00;
  localparam logic CTRL_PRESC_RESET = 1'b0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_FIRST = 2'b01, ST_SECOND = 2'b11
  } exec_state_t;

  typedef enum logic [5:0] {
    NO_OPERATION, ADD_ACC_TO_REG, AND_ACC_WITH_REG, CLEAR_REG,
    CLEAR_ACC, INVERT_REG, DECREMENT_REG, DECREMENT_SKIP_ZERO,
    INCREMENT_REG, INCREMENT_SKIP_ZERO, OR_ACC_WITH_REG, MOVE_REG,
    STORE_ACC_TO_REG, ROTATE_LEFT_CARRY, ROTATE_RIGHT_CARRY,
    SUB_ACC_FROM_REG, SWAP_REG_NIBBLES, XOR_ACC_WITH_REG,
    CLEAR_REG_BIT, SET_REG_BIT, TEST_BIT_SKIP_CLEAR, TEST_BIT_SKIP_SET,
    ADD_LITERAL, AND_LITERAL, CALL_SUBROUTINE, CLEAR_WATCHDOG,
    JUMP_ABSOLUTE, OR_LITERAL, LOAD_LITERAL, RETURN_FROM_IRQ,
    RETURN_WITH_LITERAL, RETURN_FROM_SUB, ENTER_STANDBY,
    LITERAL_MINUS_ACC, XOR_LITERAL
  } op_t;

  typedef struct packed {
    op_t op;
    logic dest_reg;
    logic writes_file;
    logic [3:0] flags;
    logic fixed_two;
    logic can_skip;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [10:0] literal;
  } decode_t;

endpackage

// ==== design/risc_instr_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module risc_instr_decoder
  import risc_decode_pkg::*;
#(
  parameter logic [6:0] TIMER_ZERO_ADDR = TIMER_ZERO_ADDR_DEF
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Decoded instruction towards the datapath
  output decode_t dec_out,
  output logic two_cycle_out,
  output logic exec_busy,
  output logic cycle_end,
  output logic prescaler_clear
);

  // ==========================================================
  // Bus request decode
  logic dp_wr_reg; // Write data phase pending
  logic [7:0] dp_addr_reg; // Address of pending data phase
  logic [31:0] hrdata_reg; // Read data held for the data phase
  logic [31:0] rd_mux; // Read value for the address phase

  wire addr_take = hsel & hready & htrans[1];
  wire rd_take = addr_take & ~hwrite;
  wire wr_take = addr_take & hwrite;
  wire [7:0] req_addr = haddr[7:0];
  wire size_word = (hsize == 3'h2);

  // ==========================================================
  // Software registers
  logic [13:0] instr_reg; // Word to be decoded
  logic [7:0] operand_reg; // Value of the addressed register
  logic presc_to_timer_reg; // Prescaler assigned to timer
  logic start_pend_reg; // Instruction written, not yet begun
  logic [7:0] exec_count_reg; // Completed instructions

  // ==========================================================
  // Sequencer state
  exec_state_t state_reg;
  exec_state_t state_next;
  logic [1:0] phase_reg; // Oscillator period within a cycle
  decode_t dec_reg; // Decode latched at start
  logic two_cycle_reg; // Current instruction needs two cycles
  logic skip_reg; // Skip was taken
  logic presc_clr_reg; // Prescaler clear pulse
  logic start_reg; // One-cycle start strobe

  wire busy = (state_reg != ST_IDLE) | start_pend_reg | start_reg;
  wire wr_data = dp_wr_reg;
  wire wr_instr = wr_data & (dp_addr_reg == OFF_INSTR) & ~busy;
  wire wr_operand = wr_data & (dp_addr_reg == OFF_OPERAND);
  wire wr_ctrl = wr_data & (dp_addr_reg == OFF_CTRL);
  wire period_last = (phase_reg == PHASE_LAST);
  wire cyc_end = (state_reg != ST_IDLE) & period_last;

  // ==========================================================
  // Instruction fields
  wire [1:0] grp = instr_reg[13:12];
  wire [3:0] sub = instr_reg[11:8];
  wire dbit = instr_reg[7];
  wire [6:0] faddr = instr_reg[6:0];
  wire [2:0] bsel = instr_reg[9:7];
  wire nop_pattern = (instr_reg[13:7] == 7'h00) &
                     (instr_reg[4:0] == 5'h00);
  decode_t dec_comb;

  // Main instruction decode
  always_comb begin
    dec_comb = '0;
    dec_comb.op = NO_OPERATION;
    dec_comb.file_addr = faddr;
    dec_comb.bit_sel = bsel;
    dec_comb.literal = instr_reg[10:0];
    case (grp)
      // Byte-oriented file register operations
      GRP_BYTE: begin
        dec_comb.dest_reg = dbit;
        dec_comb.writes_file = dbit;
        case (sub)
          4'h0: begin
            if (dbit) begin
              // Store accumulator, no flags
              dec_comb.op = STORE_ACC_TO_REG;
            end else if (instr_reg == WORD_RETURN_SUB) begin
              dec_comb.op = RETURN_FROM_SUB;
              dec_comb.fixed_two = 1'b1;
            end else if (instr_reg == WORD_RETURN_IRQ) begin
              dec_comb.op = RETURN_FROM_IRQ;
              dec_comb.fixed_two = 1'b1;
            end else if (instr_reg == WORD_CLEAR_WDOG) begin
              dec_comb.op = CLEAR_WATCHDOG;
              dec_comb.flags = FLAGS_TOPD;
            end else if (instr_reg == WORD_STANDBY) begin
              dec_comb.op = ENTER_STANDBY;
              dec_comb.flags = FLAGS_TOPD;
            end else if (nop_pattern) begin
              // Bits 6:5 ignored
              dec_comb.op = NO_OPERATION;
            end else begin
              // Unlisted word
              dec_comb.op = NO_OPERATION;
            end
          end
          4'h1: begin
            if (dbit) begin
              dec_comb.op = CLEAR_REG;
              dec_comb.flags = FLAGS_Z;
            end else if (faddr == CLEAR_ACC_LOW) begin
              dec_comb.op = CLEAR_ACC;
              dec_comb.flags = FLAGS_Z;
            end else begin
              dec_comb.op = NO_OPERATION;
            end
          end
          4'h2: begin
            dec_comb.op = SUB_ACC_FROM_REG;
            dec_comb.flags = FLAGS_CDZ;
          end
          4'h3: begin
            dec_comb.op = DECREMENT_REG;
            dec_comb.flags = FLAGS_Z;
          end
          4'h4: begin
            dec_comb.op = OR_ACC_WITH_REG;
            dec_comb.flags = FLAGS_Z;
          end
          4'h5: begin
            dec_comb.op = AND_ACC_WITH_REG;
            dec_comb.flags = FLAGS_Z;
          end
          4'h6: begin
            dec_comb.op = XOR_ACC_WITH_REG;
            dec_comb.flags = FLAGS_Z;
          end
          4'h7: begin
            dec_comb.op = ADD_ACC_TO_REG;
            dec_comb.flags = FLAGS_CDZ;
          end
          4'h8: begin
            dec_comb.op = MOVE_REG;
            dec_comb.flags = FLAGS_Z;
          end
          4'h9: begin
            dec_comb.op = INVERT_REG;
            dec_comb.flags = FLAGS_Z;
          end
          4'hA: begin
            dec_comb.op = INCREMENT_REG;
            dec_comb.flags = FLAGS_Z;
          end
          4'hB: begin
            dec_comb.op = DECREMENT_SKIP_ZERO;
            dec_comb.can_skip = 1'b1;
          end
          4'hC: begin
            dec_comb.op = ROTATE_RIGHT_CARRY;
            dec_comb.flags = FLAGS_C;
          end
          4'hD: begin
            dec_comb.op = ROTATE_LEFT_CARRY;
            dec_comb.flags = FLAGS_C;
          end
          4'hE: begin
            dec_comb.op = SWAP_REG_NIBBLES;
          end
          4'hF: begin
            dec_comb.op = INCREMENT_SKIP_ZERO;
            dec_comb.can_skip = 1'b1;
          end
          default: begin
            dec_comb.dest_reg = 1'b0;
            dec_comb.writes_file = 1'b0;
          end
        endcase
      end
      // Bit-oriented file register operations
      GRP_BIT: begin
        case (instr_reg[11:10])
          2'h0: begin
            dec_comb.op = CLEAR_REG_BIT;
            dec_comb.writes_file = 1'b1;
            dec_comb.dest_reg = 1'b1;
          end
          2'h1: begin
            dec_comb.op = SET_REG_BIT;
            dec_comb.writes_file = 1'b1;
            dec_comb.dest_reg = 1'b1;
          end
          2'h2: begin
            dec_comb.op = TEST_BIT_SKIP_CLEAR;
            dec_comb.can_skip = 1'b1;
          end
          default: begin
            dec_comb.op = TEST_BIT_SKIP_SET;
            dec_comb.can_skip = 1'b1;
          end
        endcase
      end
      // Program transfers, 11-bit target
      GRP_XFER: begin
        dec_comb.fixed_two = 1'b1;
        if (instr_reg[11]) begin
          dec_comb.op = JUMP_ABSOLUTE;
        end else begin
          dec_comb.op = CALL_SUBROUTINE;
        end
      end
      // Literal operations, 8-bit literal
      default: begin
        dec_comb.literal = {3'h0, instr_reg[7:0]};
        casez (sub)
          4'b00??: dec_comb.op = LOAD_LITERAL;
          4'b01??: begin
            dec_comb.op = RETURN_WITH_LITERAL;
            dec_comb.fixed_two = 1'b1;
          end
          4'b110?: begin
            dec_comb.op = LITERAL_MINUS_ACC;
            dec_comb.flags = FLAGS_CDZ;
          end
          4'b111?: begin
            dec_comb.op = ADD_LITERAL;
            dec_comb.flags = FLAGS_CDZ;
          end
          4'b1000: begin
            dec_comb.op = OR_LITERAL;
            dec_comb.flags = FLAGS_Z;
          end
          4'b1001: begin
            dec_comb.op = AND_LITERAL;
            dec_comb.flags = FLAGS_Z;
          end
          4'b1010: begin
            dec_comb.op = XOR_LITERAL;
            dec_comb.flags = FLAGS_Z;
          end
          default: dec_comb.op = NO_OPERATION;
        endcase
      end
    endcase
  end

  // ==========================================================
  // Skip condition and prescaler hit
  wire tested_bit = operand_reg[bsel];
  wire skip_now = (dec_comb.op == DECREMENT_SKIP_ZERO &&
                   operand_reg == 8'h01) ||
                  (dec_comb.op == INCREMENT_SKIP_ZERO &&
                   operand_reg == 8'hFF) ||
                  (dec_comb.op == TEST_BIT_SKIP_CLEAR &&
                   !tested_bit) ||
                  (dec_comb.op == TEST_BIT_SKIP_SET && tested_bit);
  wire two_now = dec_comb.fixed_two |
                 (dec_comb.can_skip & skip_now);
  wire timer_hit = dec_comb.writes_file &
                   (faddr == TIMER_ZERO_ADDR) &
                   presc_to_timer_reg;

  // Next sequencer state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_reg) begin
          state_next = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (period_last) begin
          state_next = two_cycle_reg ? ST_SECOND : ST_IDLE;
        end
      end
      ST_SECOND: begin
        if (period_last) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer and period divider
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_IDLE;
      phase_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      // Four oscillator periods per cycle
      phase_reg <= (state_reg == ST_IDLE) ? 2'h0 :
                   phase_reg + 2'h1;
    end
  end

  // Latch decode when execution begins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dec_reg <= '0;
      two_cycle_reg <= 1'b0;
      skip_reg <= 1'b0;
      presc_clr_reg <= 1'b0;
    end else begin
      presc_clr_reg <= start_reg & timer_hit;
      if (start_reg) begin
        dec_reg <= dec_comb;
        two_cycle_reg <= two_now;
        skip_reg <= dec_comb.can_skip & skip_now;
      end
    end
  end

  // Start handshake and completion count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_pend_reg <= 1'b0;
      start_reg <= 1'b0;
      exec_count_reg <= 8'h00;
    end else begin
      start_pend_reg <= wr_instr;
      start_reg <= start_pend_reg;
      if (cyc_end && state_next == ST_IDLE) begin
        exec_count_reg <= exec_count_reg + 8'h01;
      end
    end
  end

  // ==========================================================
  // Register writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_reg <= INSTR_RESET;
      operand_reg <= OPERAND_RESET;
      presc_to_timer_reg <= CTRL_PRESC_RESET;
    end else begin
      if (wr_instr) begin
        instr_reg <= hwdata[13:0];
      end
      if (wr_operand) begin
        operand_reg <= hwdata[7:0];
      end
      if (wr_ctrl) begin
        presc_to_timer_reg <= hwdata[0];
      end
    end
  end

  // Read value selection
  wire [31:0] rd_decode = {6'h00, dec_reg.op, dec_reg.flags,
                           dec_reg.dest_reg, dec_reg.writes_file,
                           dec_reg.can_skip, dec_reg.fixed_two,
                           1'b0, dec_reg.bit_sel, 1'b0,
                           dec_reg.file_addr};
  wire [31:0] rd_status = {16'h0000, exec_count_reg, 2'h0, phase_reg,
                           state_reg, skip_reg, busy};
  always_comb begin
    case (req_addr)
      OFF_INSTR: rd_mux = {18'h00000, instr_reg};
      OFF_OPERAND: rd_mux = {24'h000000, operand_reg};
      OFF_CTRL: rd_mux = {31'h00000000, presc_to_timer_reg};
      OFF_DECODE: rd_mux = rd_decode;
      OFF_LITERAL: rd_mux = {21'h000000, dec_reg.literal};
      OFF_STATUS: rd_mux = rd_status;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      dp_wr_reg <= wr_take & size_word;
      dp_addr_reg <= req_addr;
      if (rd_take) begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign dec_out = dec_reg;
  assign two_cycle_out = two_cycle_reg;
  assign exec_busy = busy;
  assign cycle_end = cyc_end;
  assign prescaler_clear = presc_clr_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence one_cycle_s;
    (state_reg == ST_FIRST) [*4];
  endsequence
  sequence second_cycle_s;
    (state_reg == ST_SECOND) [*4];
  endsequence

  field_route_a: assert property (
    start_reg |=> dec_out.file_addr == $past(faddr) &&
    dec_out.bit_sel == $past(bsel))
    else $error("field routing wrong");
  dest_select_a: assert property (
    (grp == GRP_BYTE && sub >= 4'h2) |-> dec_comb.dest_reg == dbit)
    else $error("destination select wrong");
  dont_care_a: assert property (
    nop_pattern |-> dec_comb.op == NO_OPERATION)
    else $error("dont care bits changed op");
  add_flags_a: assert property (
    (grp == GRP_BYTE && sub == 4'h7) |->
    dec_comb.op == ADD_ACC_TO_REG && dec_comb.flags == FLAGS_CDZ)
    else $error("add flags wrong");
  rotate_flags_a: assert property (
    (grp == GRP_BYTE && sub[3:1] == 3'h6) |->
    dec_comb.flags == FLAGS_C)
    else $error("rotate flags wrong");
  xfer_two_a: assert property (
    grp == GRP_XFER |-> dec_comb.fixed_two &&
    dec_comb.op == (instr_reg[11] ? JUMP_ABSOLUTE : CALL_SUBROUTINE))
    else $error("transfer decode wrong");
  lit_xor_a: assert property (
    (grp == GRP_LIT && sub == 4'hA) |->
    dec_comb.op == XOR_LITERAL && dec_comb.flags == FLAGS_Z)
    else $error("literal xor decode wrong");
  one_cycle_a: assert property (
    start_reg ##1 !two_cycle_reg |-> one_cycle_s ##1
    state_reg == ST_IDLE)
    else $error("one cycle length wrong");
  two_cycle_a: assert property (
    start_reg ##1 two_cycle_reg |-> one_cycle_s ##1 second_cycle_s
    ##1 state_reg == ST_IDLE)
    else $error("two cycle length wrong");
  bit_skip_a: assert property (
    start_reg && dec_comb.op == TEST_BIT_SKIP_SET |=>
    two_cycle_reg == $past(tested_bit))
    else $error("bit test skip wrong");
  presc_clear_a: assert property (
    start_reg && dec_comb.writes_file && faddr == TIMER_ZERO_ADDR &&
    presc_to_timer_reg |=> prescaler_clear ##1 !prescaler_clear)
    else $error("prescaler clear missing");
  unknown_nop_a: assert property (
    dec_comb.op == NO_OPERATION |-> dec_comb.flags == FLAGS_NONE &&
    !dec_comb.writes_file && !dec_comb.fixed_two)
    else $error("unknown word has effect");

endmodule

`default_nettype wire

// ==== verif/risc_14bit_instruction_decoder_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

module risc_14bit_instruction_decoder_bench;
  import risc_decode_pkg::*;
  // ==========================================================
  // Bus, decode and bookkeeping signals
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, two_cycle_out, exec_busy, cycle_end;
  logic prescaler_clear;
  decode_t dec_out;
  int error_cnt = 0; // Mismatches
  int checks = 0; // Comparisons
  int pcl; // Prescaler clear pulses seen in one run

  risc_instr_decoder risc_instr_decoder_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .dec_out(dec_out), .two_cycle_out(two_cycle_out),
    .exec_busy(exec_busy), .cycle_end(cycle_end),
    .prescaler_clear(prescaler_clear));

  // ==========================================================
  // Clock, verdict and comparison
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // One single AHB-Lite word transfer, waiting on hready
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Execute one word, count cycle ends, judge decode and length
  task automatic run(input logic [13:0] w, input logic [7:0] opnd,
                     input op_t eop, input logic [3:0] efl, input int ncyc);
    int n, ends, first, last;
    bus(1'b1, OFF_OPERAND, {24'h000000, opnd}, rq);
    bus(1'b1, OFF_INSTR, {18'h00000, w}, rq);
    n = 0;
    ends = 0;
    first = 0;
    last = 0;
    pcl = 0;
    while ((n < 2 || exec_busy === 1'b1) && n < 60) begin
      @(posedge hclk);
      n++;
      if (prescaler_clear === 1'b1) pcl++;
      if (cycle_end === 1'b1) begin
        ends++;
        if (ends == 1) first = n;
        last = n;
      end
    end
    chk(ends, ncyc);
    if (ncyc == 2) chk(last - first, OSC_PERIODS_PER_CYCLE);
    chk(dec_out.op, eop);
    chk(dec_out.flags, efl);
    chk(two_cycle_out, (ncyc == 2));
    bus(1'b0, OFF_DECODE, 32'h0, rq);
    chk(rq[25:20], eop);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(dec_out.op, NO_OPERATION);
    bus(1'b0, 8'h40, 32'h0, rq);
    chk(rq, 32'h00000000);
    chk(hresp, 1'b0);
    chk(hreadyout, 1'b1);
  endtask

  task automatic t_byte();
    run(14'h07FF, 8'h00, ADD_ACC_TO_REG, FLAGS_CDZ, 1);
    chk(dec_out.dest_reg, 1'b1);
    run(14'h027F, 8'h00, SUB_ACC_FROM_REG, FLAGS_CDZ, 1);
    chk(dec_out.dest_reg, 1'b0);
    run(14'h0AFF, 8'h00, INCREMENT_REG, FLAGS_Z, 1);
    run(14'h03FF, 8'h00, DECREMENT_REG, FLAGS_Z, 1);
    run(14'h09FF, 8'h00, INVERT_REG, FLAGS_Z, 1);
    run(14'h08FF, 8'h00, MOVE_REG, FLAGS_Z, 1);
    run(14'h0EFF, 8'h00, SWAP_REG_NIBBLES, FLAGS_NONE, 1);
    run(14'h05FF, 8'h00, AND_ACC_WITH_REG, FLAGS_Z, 1);
    run(14'h04FF, 8'h00, OR_ACC_WITH_REG, FLAGS_Z, 1);
    run(14'h06FF, 8'h00, XOR_ACC_WITH_REG, FLAGS_Z, 1);
    run(14'h0DFF, 8'h00, ROTATE_LEFT_CARRY, FLAGS_C, 1);
    run(14'h0CFF, 8'h00, ROTATE_RIGHT_CARRY, FLAGS_C, 1);
    run(14'h00FF, 8'h00, STORE_ACC_TO_REG, FLAGS_NONE, 1);
    run(14'h0060, 8'h00, NO_OPERATION, FLAGS_NONE, 1);
    run(14'h01FF, 8'h00, CLEAR_REG, FLAGS_Z, 1);
    run(14'h0103, 8'h00, CLEAR_ACC, FLAGS_Z, 1);
    run(14'h0105, 8'h00, NO_OPERATION, FLAGS_NONE, 1);
  endtask

  task automatic t_skip();
    run(14'h0BFF, 8'h01, DECREMENT_SKIP_ZERO, FLAGS_NONE, 2);
    run(14'h0BFF, 8'h05, DECREMENT_SKIP_ZERO, FLAGS_NONE, 1);
    run(14'h0FFF, 8'hFF, INCREMENT_SKIP_ZERO, FLAGS_NONE, 2);
    run(14'h0FFF, 8'h00, INCREMENT_SKIP_ZERO, FLAGS_NONE, 1);
  endtask

  task automatic t_bit();
    run(14'h13FF, 8'h00, CLEAR_REG_BIT, FLAGS_NONE, 1);
    run(14'h17FF, 8'h00, SET_REG_BIT, FLAGS_NONE, 1);
    run(14'h1BFF, 8'h7F, TEST_BIT_SKIP_CLEAR, FLAGS_NONE, 2);
    chk(dec_out.file_addr, 7'h7F);
    chk(dec_out.bit_sel, 3'h7);
    run(14'h1BFF, 8'h80, TEST_BIT_SKIP_CLEAR, FLAGS_NONE, 1);
    run(14'h1FFF, 8'h80, TEST_BIT_SKIP_SET, FLAGS_NONE, 2);
    run(14'h1FFF, 8'h00, TEST_BIT_SKIP_SET, FLAGS_NONE, 1);
  endtask

  task automatic t_lit_ctrl();
    run(14'h27FF, 8'h00, CALL_SUBROUTINE, FLAGS_NONE, 2);
    run(14'h2FFF, 8'h00, JUMP_ABSOLUTE, FLAGS_NONE, 2);
    chk(dec_out.literal, 11'h7FF);
    run(14'h0008, 8'h00, RETURN_FROM_SUB, FLAGS_NONE, 2);
    run(14'h0009, 8'h00, RETURN_FROM_IRQ, FLAGS_NONE, 2);
    run(14'h0064, 8'h00, CLEAR_WATCHDOG, FLAGS_TOPD, 1);
    run(14'h0063, 8'h00, ENTER_STANDBY, FLAGS_TOPD, 1);
    run(14'h3355, 8'h00, LOAD_LITERAL, FLAGS_NONE, 1);
    chk(dec_out.literal[7:0], 8'h55);
    run(14'h3755, 8'h00, RETURN_WITH_LITERAL, FLAGS_NONE, 2);
    run(14'h3D55, 8'h00, LITERAL_MINUS_ACC, FLAGS_CDZ, 1);
    run(14'h3E55, 8'h00, ADD_LITERAL, FLAGS_CDZ, 1);
    run(14'h3855, 8'h00, OR_LITERAL, FLAGS_Z, 1);
    run(14'h3955, 8'h00, AND_LITERAL, FLAGS_Z, 1);
    run(14'h3A55, 8'h00, XOR_LITERAL, FLAGS_Z, 1);
    run(14'h3B55, 8'h00, NO_OPERATION, FLAGS_NONE, 1);
  endtask

  task automatic t_presc();
    bus(1'b1, OFF_CTRL, 32'h1, rq);
    run(14'h0781, 8'h00, ADD_ACC_TO_REG, FLAGS_CDZ, 1);
    chk(pcl, 1);
    run(14'h0701, 8'h00, ADD_ACC_TO_REG, FLAGS_CDZ, 1);
    chk(pcl, 0);
    bus(1'b1, OFF_CTRL, 32'h0, rq);
    run(14'h0781, 8'h00, ADD_ACC_TO_REG, FLAGS_CDZ, 1);
    chk(pcl, 0);
  endtask

  // A word written while busy must not replace the running one
  task automatic t_refuse();
    int n;
    bus(1'b1, OFF_INSTR, 32'h00002FFF, rq);
    bus(1'b1, OFF_INSTR, 32'h00000000, rq);
    n = 0;
    while (exec_busy === 1'b1 && n < 60) begin
      @(posedge hclk);
      n++;
    end
    chk(dec_out.op, JUMP_ABSOLUTE);
    bus(1'b0, OFF_INSTR, 32'h0, rq);
    chk(rq, 32'h00002FFF);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_byte();
    t_skip();
    t_bit();
    t_lit_ctrl();
    t_presc();
    t_refuse();
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    give_verdict();
  end
endmodule

`default_nettype wire
